// >>> ddr_burst_host.sv
`timescale 1ns/10ps
`include "ddr_burst_consts.svh"
module burst_req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `REQ_FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_mem [DEPTH];
  logic [PW-1:0]    wp;
  logic [PW-1:0]    rp;
  logic [PW:0]      count;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign out_data_o = buf_mem[rp];
  assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wp          <= '0;
      rp          <= '0;
      count       <= '0;
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      wp          <= push ? PW'((wp + 1'b1) % DEPTH) : wp;
      rp          <= pop ? PW'((rp + 1'b1) % DEPTH) : rp;
      count       <= next_count;
      in_ready_o  <= next_count != (PW+1)'(DEPTH);
      out_valid_o <= next_count != '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      buf_mem[wp] <= in_data_i;
    end
  end
endmodule : burst_req_fifo

module ddr_burst_host #(
  parameter int W  = `WORD_WIDTH_DEF,
  parameter int AW = `ADDR_WIDTH_DEF
) (
  input  wire logic          CLK_I,
  input  wire logic          RESETN_I,
  ddr_burst_if.host          LINK,
  input  wire logic          USE_OUT_CLK_I,
  input  wire logic          REQ_VALID_I,
  output logic               REQ_READY_O,
  input  wire logic          REQ_WRITE_I,
  input  wire logic [AW-1:0] REQ_ADDR_I,
  input  wire logic [W-1:0]  REQ_WDATA0_I,
  input  wire logic [W-1:0]  REQ_WDATA1_I,
  output logic               RD_VALID_O,
  output logic [W-1:0]       RD_DATA0_O,
  output logic [W-1:0]       RD_DATA1_O
);
  import ddr_burst_pkg::*;

  localparam int FW = 1 + AW + 2 * W;
  localparam int DW = 4;

  // ****************************************
  // request buffer
  // ****************************************
  logic          f_valid;
  logic          f_ready;
  logic [FW-1:0] f_data;

  burst_req_fifo #(.WIDTH(FW), .DEPTH(`REQ_FIFO_DEPTH)) burst_req_fifo_i (
    .clk_i       (CLK_I),
    .resetn_i    (RESETN_I),
    .in_valid_i  (REQ_VALID_I),
    .in_ready_o  (REQ_READY_O),
    .in_data_i   ({REQ_WRITE_I, REQ_ADDR_I, REQ_WDATA0_I, REQ_WDATA1_I}),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  // ****************************************
  // read capture, two flops from the pins
  // ****************************************
  logic [W+1:0] rs1;
  logic [W+1:0] rs2;
  logic [1:0]   echo_prev;
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rs1       <= '0;
      rs2       <= '0;
      echo_prev <= '0;
    end else begin
      rs1       <= {LINK.echo_clock, LINK.echo_clock_n, LINK.dq};
      rs2       <= rs1;
      echo_prev <= rs2[W+1:W];
    end
  end
  logic echo_rise;
  logic echo_n_rise;
  assign echo_rise   = rs2[W+1] & ~echo_prev[1];
  assign echo_n_rise = rs2[W]   & ~echo_prev[0];

  // ****************************************
  // clock divider and sequencer
  // ****************************************
  host_t          state;
  host_t          next_state;
  logic [DW-1:0]  div;
  logic [DW-1:0]  next_div;
  logic           k;
  logic           next_k;
  logic           c;
  logic           next_c;
  logic           load_n;
  logic           next_load_n;
  logic           rw;
  logic           next_rw;
  logic [AW-1:0]  addr;
  logic [AW-1:0]  next_addr;
  logic [W-1:0]   dq;
  logic [W-1:0]   next_dq;
  logic           dq_oe;
  logic           next_dq_oe;
  logic [W-1:0]   wd1;
  logic [W-1:0]   next_wd1;
  logic           rd_valid;
  logic           next_rd_valid;
  logic [W-1:0]   rd0;
  logic [W-1:0]   next_rd0;
  logic [W-1:0]   rd1;
  logic [W-1:0]   next_rd1;
  logic           mid;
  logic           skip;
  logic           next_skip;

  // pins change one cycle after mid half-period, one system clock before the next sampling rise
  assign mid = (div == DW'(`LINK_MID_CYCLE));

  always_comb begin
    next_state    = state;
    next_load_n   = load_n;
    next_rw       = rw;
    next_addr     = addr;
    next_dq       = dq;
    next_dq_oe    = dq_oe;
    next_wd1      = wd1;
    next_rd_valid = 1'b0;
    next_rd0      = rd0;
    next_rd1      = rd1;
    next_skip     = skip;
    f_ready       = 1'b0;
    // divider from own clock; half period fixed so rate stays legal
    next_div = (div == DW'(`LINK_HALF_CYCLES - 1)) ? '0 : div + 1'b1;
    next_k   = (div == DW'(`LINK_HALF_CYCLES - 1)) ? ~k : k;
    next_c   = USE_OUT_CLK_I & next_k;

    case (state)
      H_IDLE: begin
        if (mid && !k && f_valid) begin
          f_ready     = 1'b1;
          next_load_n = 1'b0;
          next_rw     = ~f_data[FW-1];
          next_addr   = f_data[FW-2 -: AW];
          next_dq     = f_data[2*W-1 -: W];
          next_wd1    = f_data[W-1:0];
          next_state  = H_CMD;
        end
      end
      H_CMD: begin
        if (mid && k) begin
          next_load_n = 1'b1;
          next_dq_oe  = ~rw;
          next_skip   = rw;
          next_state  = rw ? H_RWAIT0 : H_WDATA;
        end
      end
      H_WDATA: begin
        if (mid && !k) begin
          next_dq    = wd1;
          next_state = H_WEND;
        end
      end
      H_WEND: begin
        if (mid && k) begin
          next_dq_oe = 1'b0;
          next_state = H_IDLE;
        end
      end
      H_RWAIT0: begin
        // echoes run free: the rise of the accepting period carries no data
        if (skip) begin
          if (mid && !k) begin
            next_skip = 1'b0;
          end
        end else if (echo_rise) begin
          next_rd0   = rs2[W-1:0];
          next_state = H_RWAIT1;
        end
      end
      H_RWAIT1: begin
        if (echo_n_rise) begin
          next_rd1      = rs2[W-1:0];
          next_rd_valid = 1'b1;
          next_state    = H_GAP;
        end
      end
      H_GAP: begin
        // a wait for the next mid point, at most a half period, lets the device release the bus
        if (mid) begin
          next_state = H_IDLE;
        end
      end
      default: begin
        next_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      state    <= H_IDLE;
      div      <= '0;
      k        <= 1'b0;
      c        <= 1'b0;
      load_n   <= 1'b1;
      rw       <= 1'b1;
      addr     <= '0;
      dq       <= '0;
      dq_oe    <= 1'b0;
      wd1      <= '0;
      rd_valid <= 1'b0;
      rd0      <= '0;
      rd1      <= '0;
      skip     <= 1'b0;
    end else begin
      state    <= next_state;
      div      <= next_div;
      k        <= next_k;
      c        <= next_c;
      load_n   <= next_load_n;
      rw       <= next_rw;
      addr     <= next_addr;
      dq       <= next_dq;
      dq_oe    <= next_dq_oe;
      wd1      <= next_wd1;
      rd_valid <= next_rd_valid;
      rd0      <= next_rd0;
      rd1      <= next_rd1;
      skip     <= next_skip;
    end
  end

  logic kn_q;
  logic cn_q;
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      kn_q <= 1'b1;
      cn_q <= 1'b0;
    end else begin
      kn_q <= ~next_k;
      cn_q <= USE_OUT_CLK_I & ~next_k;
    end
  end

  assign LINK.k             = k;
  assign LINK.k_n           = kn_q;
  assign LINK.c             = c;
  assign LINK.c_n           = cn_q;
  assign LINK.load_select_n = load_n;
  assign LINK.rw            = rw;
  assign LINK.addr          = addr;
  assign LINK.host_dq       = dq;
  assign LINK.host_dq_oe    = dq_oe;
  assign RD_VALID_O         = rd_valid;
  assign RD_DATA0_O         = rd0;
  assign RD_DATA1_O         = rd1;
endmodule : ddr_burst_host

// >>> ddr_burst_consts.svh
`ifndef DDR_BURST_CONSTS_SVH
`define DDR_BURST_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS      100
`define LINK_PERIOD_NS     800
`define LINK_HALF_CYCLES   (`LINK_PERIOD_NS / (2 * `CLK_PERIOD_NS))
`define LINK_MID_CYCLE     (`LINK_HALF_CYCLES / 2)
`define MAX_LINK_FREQ_MHZ  300
`define SINGLE_DETECT_RISE 2

// ****************************************
// organisation
// ****************************************
`define WORD_WIDTH_DEF     18
`define ADDR_WIDTH_DEF     4
`define LSB_START_MIN_W    18
`define REQ_FIFO_DEPTH     4

`endif

// >>> ddr_burst_pkg.sv
package ddr_burst_pkg;
  typedef enum logic [2:0] {RD_IDLE, RD_ARM, RD_READY, RD_WORD0, RD_WORD1} dev_rd_t;
  typedef enum logic [1:0] {WR_IDLE, WR_WORD0, WR_WORD1} dev_wr_t;
  typedef enum logic [2:0] {
    H_IDLE, H_CMD, H_WDATA, H_WEND, H_RWAIT0, H_RWAIT1, H_GAP
  } host_t;
endpackage : ddr_burst_pkg

// >>> ddr_burst_if.sv
`timescale 1ns/10ps
interface ddr_burst_if #(
  parameter int W  = 18,
  parameter int AW = 4
);
  logic          k;
  logic          k_n;
  logic          c;
  logic          c_n;
  logic          load_select_n;
  logic          rw;
  logic [AW-1:0] addr;
  logic [W-1:0]  host_dq;
  logic          host_dq_oe;
  logic [W-1:0]  dev_dq;
  logic          dev_dq_oe;
  logic          echo_clock;
  logic          echo_clock_n;
  logic [W-1:0]  dq;

  // shared data bus level worked out from the two enables
  assign dq = host_dq_oe ? host_dq : (dev_dq_oe ? dev_dq : '0);

  modport dev (
    input  k, k_n, c, c_n, load_select_n, rw, addr, dq,
    output dev_dq, dev_dq_oe, echo_clock, echo_clock_n
  );
  modport host (
    output k, k_n, c, c_n, load_select_n, rw, addr, host_dq, host_dq_oe,
    input  dq, echo_clock, echo_clock_n
  );
endinterface : ddr_burst_if

// >>> ddr_burst_sram_dev.sv
`timescale 1ns/10ps
`include "ddr_burst_consts.svh"
// Function
// - address accepted on alternate input clock rises
// - write words taken on both input clock rises
// - read words launched on output clock rises
// - without output clocks, launch on input clocks
// - two words per location per burst
// - one-bit counter selects current burst word
// - narrow words: burst always starts at zero
// - wide words: burst starts at address lsb
// - every input registered before it acts
// - data outputs leave through output registers
// - array write self-timed, no extra strobes
// - echo clocks accompany read data
// - one shared data bus, turned around
// - only rising clock edges are used
// - input clock never above 300 MHz
module ddr_burst_sram_dev #(
  parameter int W  = `WORD_WIDTH_DEF,
  parameter int AW = `ADDR_WIDTH_DEF
) (
  input  wire logic CLK_I,
  input  wire logic RESETN_I,
  ddr_burst_if.dev  LINK,
  output logic      SINGLE_CLK_O
);
  import ddr_burst_pkg::*;

  localparam int  SW        = 6 + AW + W;
  localparam bit  LSB_START = (W >= `LSB_START_MIN_W);
  localparam int  MEM_WORDS = 2 ** (AW + 1);

  // ****************************************
  // input registers
  // ****************************************
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [3:0]    clk_prev;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      sync1    <= '0;
      sync2    <= '0;
      clk_prev <= '0;
    end else begin
      sync1    <= {LINK.k, LINK.k_n, LINK.c, LINK.c_n, LINK.load_select_n,
                   LINK.rw, LINK.addr, LINK.dq};
      sync2    <= sync1;
      clk_prev <= sync2[SW-1 -: 4];
    end
  end

  logic          k_s;
  logic          kn_s;
  logic          c_s;
  logic          cn_s;
  logic          load_n_s;
  logic          rw_s;
  logic [AW-1:0] addr_s;
  logic [W-1:0]  dq_s;
  assign {k_s, kn_s, c_s, cn_s, load_n_s, rw_s, addr_s, dq_s} = sync2;

  // falling edges are never looked at
  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  assign k_rise  = k_s  & ~clk_prev[3];
  assign kn_rise = kn_s & ~clk_prev[2];
  assign c_rise  = c_s  & ~clk_prev[1];
  assign cn_rise = cn_s & ~clk_prev[0];

  // ****************************************
  // state
  // ****************************************
  dev_rd_t       rd_state;
  dev_rd_t       next_rd_state;
  dev_wr_t       wr_state;
  dev_wr_t       next_wr_state;
  logic          blocked;
  logic          next_blocked;
  logic          cnt;
  logic          next_cnt;
  logic [AW-1:0] loc;
  logic [AW-1:0] next_loc;
  logic [W-1:0]  dq_out;
  logic [W-1:0]  next_dq_out;
  logic          dq_oe;
  logic          next_dq_oe;
  logic          echo;
  logic          next_echo;
  logic          echo_n;
  logic          next_echo_n;
  logic [1:0]    miss;
  logic [1:0]    next_miss;
  logic          single;
  logic          next_single;
  logic          mem_we;
  logic [AW:0]   mem_wi;
  logic [W-1:0]  mem [MEM_WORDS];

  function automatic logic [AW:0] word_index(input logic [AW-1:0] a, input logic b);
    if (LSB_START) begin
      word_index = {1'b0, a[AW-1:1], b};
    end else begin
      word_index = {a, b};
    end
  endfunction : word_index

  logic accept;
  logic t_rise;
  logic cm_rise;
  assign accept  = k_rise & ~blocked & ~load_n_s;
  assign t_rise  = single ? k_rise  : c_rise;
  assign cm_rise = single ? kn_rise : cn_rise;

  always_comb begin
    next_rd_state = rd_state;
    next_wr_state = wr_state;
    next_blocked  = blocked;
    next_cnt      = cnt;
    next_loc      = loc;
    next_dq_out   = dq_out;
    next_dq_oe    = dq_oe;
    next_miss     = miss;
    next_single   = single;
    mem_we        = 1'b0;
    mem_wi        = word_index(loc, cnt);
    next_echo     = single ? k_s  : c_s;
    next_echo_n   = single ? kn_s : cn_s;

    // output clocks counted absent after a few input rises without one
    if (c_rise) begin
      next_miss   = '0;
      next_single = 1'b0;
    end else if (k_rise && miss != 2'(`SINGLE_DETECT_RISE)) begin
      next_miss = miss + 2'h1;
    end else if (miss == 2'(`SINGLE_DETECT_RISE)) begin
      next_single = 1'b1;
    end

    if (k_rise) begin
      next_blocked = ~blocked & ~load_n_s;
    end

    case (wr_state)
      WR_WORD0: begin
        if (kn_rise) begin
          mem_we        = 1'b1;
          next_cnt      = ~cnt;
          next_wr_state = WR_WORD1;
        end
      end
      WR_WORD1: begin
        if (k_rise) begin
          mem_we        = 1'b1;
          next_cnt      = ~cnt;
          next_wr_state = WR_IDLE;
        end
      end
      default: begin
        next_wr_state = WR_IDLE;
      end
    endcase

    case (rd_state)
      RD_ARM: begin
        // skip a lagging output clock rise from the accepting period
        if (kn_rise) begin
          next_rd_state = RD_READY;
        end
      end
      RD_READY: begin
        if (t_rise) begin
          next_dq_out   = mem[word_index(loc, cnt)];
          next_dq_oe    = 1'b1;
          next_cnt      = ~cnt;
          next_rd_state = RD_WORD0;
        end
      end
      RD_WORD0: begin
        if (cm_rise) begin
          next_dq_out   = mem[word_index(loc, cnt)];
          next_cnt      = ~cnt;
          next_rd_state = RD_WORD1;
        end
      end
      RD_WORD1: begin
        if (t_rise) begin
          next_dq_oe    = 1'b0;
          next_rd_state = RD_IDLE;
        end
      end
      default: begin
        next_rd_state = RD_IDLE;
      end
    endcase

    if (accept) begin
      next_loc = addr_s;
      next_cnt = LSB_START ? addr_s[0] : 1'b0;
      if (rw_s) begin
        next_rd_state = RD_ARM;
        next_dq_oe    = 1'b0;
      end else begin
        next_wr_state = WR_WORD0;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rd_state <= RD_IDLE;
      wr_state <= WR_IDLE;
      blocked  <= 1'b0;
      cnt      <= 1'b0;
      loc      <= '0;
      dq_out   <= '0;
      dq_oe    <= 1'b0;
      echo     <= 1'b0;
      echo_n   <= 1'b0;
      miss     <= '0;
      single   <= 1'b0;
    end else begin
      rd_state <= next_rd_state;
      wr_state <= next_wr_state;
      blocked  <= next_blocked;
      cnt      <= next_cnt;
      loc      <= next_loc;
      dq_out   <= next_dq_out;
      dq_oe    <= next_dq_oe;
      echo     <= next_echo;
      echo_n   <= next_echo_n;
      miss     <= next_miss;
      single   <= next_single;
    end
  end

  // array keeps contents across reset, as a memory would
  always_ff @(posedge CLK_I) begin
    if (mem_we) begin
      mem[mem_wi] <= dq_s;
    end
  end

  assign LINK.dev_dq       = dq_out;
  assign LINK.dev_dq_oe    = dq_oe;
  assign LINK.echo_clock   = echo;
  assign LINK.echo_clock_n = echo_n;
  assign SINGLE_CLK_O      = single;
endmodule : ddr_burst_sram_dev

// >>> ddr_burst_link_properties.sv
`timescale 1ns/10ps
// ****************************************
// link checker
// ****************************************
module ddr_burst_link_checker (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic load_select_n_i,
  input wire logic rw_i,
  input wire logic host_dq_oe_i,
  input wire logic dev_dq_oe_i,
  input wire logic echo_clock_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_bus_one_driver: assert property (
    !(host_dq_oe_i && dev_dq_oe_i))
    else $error("both ends drive the data bus");
  a_input_clock_pair: assert property (
    k_n_i == !k_i)
    else $error("input clocks not complementary");
  a_clock_period: assert property (
    $rose(k_i) |-> k_i [*4] ##1 !k_i [*4] ##1 k_i)
    else $error("input clock period not eight system clocks");
  a_load_alternate: assert property (
    $rose(k_i) && !load_select_n_i |-> ##8 (!$rose(k_i) || load_select_n_i))
    else $error("load on two adjacent input clock rises");
  a_load_half_period: assert property (
    $fell(load_select_n_i) |-> !k_i ##0 !load_select_n_i [*4] ##1 load_select_n_i)
    else $error("load not held for one half period around a rise");
  a_host_oe_cause: assert property (
    $rose(host_dq_oe_i) |-> !$past(load_select_n_i) && load_select_n_i && !rw_i)
    else $error("host drives bus without a write load");
  a_host_two_words: assert property (
    $rose(host_dq_oe_i) |-> host_dq_oe_i [*8] ##1 !host_dq_oe_i)
    else $error("host write data not one clock period long");
  a_dev_burst_len: assert property (
    $rose(dev_dq_oe_i) |-> dev_dq_oe_i [*5] ##[0:4] !dev_dq_oe_i)
    else $error("device read burst length wrong");
  a_echo_with_data: assert property (
    $rose(dev_dq_oe_i) |-> ##[0:1] echo_clock_i [*3])
    else $error("echo clock not aligned with first read word");

  c_read_burst: cover property ($rose(dev_dq_oe_i));
  c_write_burst: cover property ($rose(host_dq_oe_i));
  c_read_load: cover property ($rose(k_i) && !load_select_n_i && rw_i);
endmodule : ddr_burst_link_checker

// >>> ddr_two_word_burst_sram_port_tb.sv
`timescale 1ns/10ps
`include "ddr_burst_consts.svh"
module ddr_two_word_burst_sram_port_tb;
  localparam int W  = `WORD_WIDTH_DEF;
  localparam int AW = `ADDR_WIDTH_DEF;
  typedef struct {logic wr; logic [AW-1:0] a; logic [W-1:0] d0; logic [W-1:0] d1;} row_t;

  logic          clk;
  logic          resetn;
  logic          use_out_clk;
  logic          req_valid;
  logic          req_ready;
  logic          req_write;
  logic [AW-1:0] req_addr;
  logic [W-1:0]  req_wdata0;
  logic [W-1:0]  req_wdata1;
  logic          rd_valid;
  logic [W-1:0]  rd_data0;
  logic [W-1:0]  rd_data1;
  logic          single_clk;
  logic          saw_full;
  int            error_cnt;
  int            cmp_count;
  int            req_cnt;
  int            load_cnt;
  int            c_cnt;
  int            cyc;

  // reads carry the words expected back, writes the words sent
  row_t rows[8] = '{
    '{1'b1, 4'h2, 18'h111A1, 18'h222B2},
    '{1'b0, 4'h2, 18'h111A1, 18'h222B2},
    '{1'b0, 4'h3, 18'h222B2, 18'h111A1},
    '{1'b1, 4'h5, 18'h033C3, 18'h044D4},
    '{1'b0, 4'h4, 18'h044D4, 18'h033C3},
    '{1'b0, 4'h5, 18'h033C3, 18'h044D4},
    '{1'b1, 4'h3, 18'h3FFFF, 18'h00000},
    '{1'b0, 4'h2, 18'h00000, 18'h3FFFF}
  };

  ddr_burst_if #(.W(W), .AW(AW)) ddr_burst_if_i ();

  ddr_burst_sram_dev #(.W(W), .AW(AW)) ddr_burst_sram_dev_i (
    .CLK_I        (clk),
    .RESETN_I     (resetn),
    .LINK         (ddr_burst_if_i),
    .SINGLE_CLK_O (single_clk)
  );

  ddr_burst_host #(.W(W), .AW(AW)) ddr_burst_host_i (
    .CLK_I         (clk),
    .RESETN_I      (resetn),
    .LINK          (ddr_burst_if_i),
    .USE_OUT_CLK_I (use_out_clk),
    .REQ_VALID_I   (req_valid),
    .REQ_READY_O   (req_ready),
    .REQ_WRITE_I   (req_write),
    .REQ_ADDR_I    (req_addr),
    .REQ_WDATA0_I  (req_wdata0),
    .REQ_WDATA1_I  (req_wdata1),
    .RD_VALID_O    (rd_valid),
    .RD_DATA0_O    (rd_data0),
    .RD_DATA1_O    (rd_data1)
  );

  ddr_burst_link_checker ddr_burst_link_checker_i (
    .clk_i           (clk),
    .resetn_i        (resetn),
    .k_i             (ddr_burst_if_i.k),
    .k_n_i           (ddr_burst_if_i.k_n),
    .load_select_n_i (ddr_burst_if_i.load_select_n),
    .rw_i            (ddr_burst_if_i.rw),
    .host_dq_oe_i    (ddr_burst_if_i.host_dq_oe),
    .dev_dq_oe_i     (ddr_burst_if_i.dev_dq_oe),
    .echo_clock_i    (ddr_burst_if_i.echo_clock)
  );

  // ****************************************
  // clock, monitors, timeout
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #(`CLK_PERIOD_NS / 2) clk = ~clk;
  end

  always @(posedge ddr_burst_if_i.k) begin
    if (ddr_burst_if_i.load_select_n === 1'b0) load_cnt++;
  end

  always @(posedge ddr_burst_if_i.c) c_cnt++;

  always @(posedge clk) begin
    cyc++;
    // two phases of 22 link operations, under 30 cycles each, fit well inside this
    if (cyc == 5000) begin
      error_cnt++;
      $display("mismatch at %0t: run did not finish in time", $time);
      stop_test();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic stop_test();
    $display("comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk_word(input logic [W-1:0] got, input logic [W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic do_reset(input logic out_clk);
    @(posedge clk);
    #1;
    resetn = 1'b0;
    use_out_clk = out_clk;
    repeat (12) @(posedge clk);
    #1;
    chk_bit(req_ready, 1'b0);
    chk_bit(ddr_burst_if_i.dev_dq_oe, 1'b0);
    chk_bit(ddr_burst_if_i.load_select_n, 1'b1);
    resetn = 1'b1;
    req_cnt = 0;
    load_cnt = 0;
    c_cnt = 0;
    saw_full = 1'b0;
  endtask : do_reset

  // one cycle gap between requests keeps valid to one change per step
  task automatic send(input logic wr, input logic [AW-1:0] a,
                      input logic [W-1:0] d0, input logic [W-1:0] d1);
    @(posedge clk);
    #1;
    req_write = wr;
    req_addr = a;
    req_wdata0 = d0;
    req_wdata1 = d1;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) begin
      saw_full = 1'b1;
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_cnt++;
  endtask : send

  task automatic read_back(input logic [W-1:0] e0, input logic [W-1:0] e1);
    for (int n = 0; n < 400 && rd_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk_bit(rd_valid, 1'b1);
    chk_word(rd_data0, e0);
    chk_word(rd_data1, e1);
  endtask : read_back

  task automatic run_phase();
    logic [AW-1:0] a;
    for (int i = 0; i < 8; i++) begin
      send(rows[i].wr, rows[i].a, rows[i].d0, rows[i].d1);
      if (!rows[i].wr) read_back(rows[i].d0, rows[i].d1);
    end
    // seven back-to-back writes to distinct locations, more than the fifo holds, so it refuses some
    for (int i = 0; i < 7; i++) begin
      a = AW'({i[2:0], i[0]});
      send(1'b1, a, W'(18'h10000 + i), W'(18'h20000 + i));
    end
    chk_bit(saw_full, 1'b1);
    for (int i = 0; i < 7; i++) begin
      a = AW'({i[2:0], i[0]});
      send(1'b0, a, '0, '0);
      read_back(W'(18'h10000 + i), W'(18'h20000 + i));
    end
    chk_bit(load_cnt == req_cnt, 1'b1);
  endtask : run_phase

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    use_out_clk = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata0 = '0;
    req_wdata1 = '0;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    do_reset(1'b1);
    run_phase();
    chk_bit(single_clk, 1'b0);
    chk_bit(c_cnt != 0, 1'b1);
    do_reset(1'b0);
    for (int n = 0; n < 200 && single_clk !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk_bit(single_clk, 1'b1);
    run_phase();
    chk_bit(c_cnt == 0, 1'b1);
    stop_test();
  end
endmodule : ddr_two_word_burst_sram_port_tb
